// file: hw/sebf_frontend.sv
// two-wire bus front end of a small serial eeprom, 512 x 8, 16 byte pages
// assumes sda is wired-and with a pull-up outside; scl comes from the master
//
// Contract
// - scl high, sda falling is start
// - nothing happens until a start
// - scl high, sda rising is stop
// - stop during read returns to standby
// - stop during write launches internal rewrite; code does so only after at least one data byte was taken
// - sda change with scl high is condition
// - sda only pulled low, otherwise released
// - sample on rising, drive on falling
// - write protect strap high blocks programming
// - rewrite ends within 10 ms
// - no acknowledge while rewrite runs
// - protection covers upper half 100h-1FFh
// - address pointer kept between accesses
module sebf_frontend
  import sebf_pkg::*;
#(
  parameter int WR_CYCLES = WR_TYP_CYC
)(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic scl,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_n,
  input  wire logic wp,
  output logic      busy
);

  // ==========================================================
  // link domain: bits are captured on scl rising edges
  logic [DW-1:0] sh_q, sh_d;
  logic          bt_q, bt_d;

  // master keeps sda stable while scl is high, so scl itself samples it
  always_comb begin
    sh_d = {sh_q[DW-2:0], sda_i};
    bt_d = ~bt_q;
  end

  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      sh_q <= '0;
      bt_q <= 1'b0;
    end else begin
      sh_q <= sh_d;
      bt_q <= bt_d;
    end
  end

  // ==========================================================
  // pin and crossing synchronisers: {scl, sda, bit toggle, wp}
  logic [3:0] s1_q, s2_q, s3_q, s_in;

  always_comb begin
    s_in = {scl, sda_i, bt_q, wp};
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 4'hC;
      s2_q <= 4'hC;
      s3_q <= 4'hC;
    end else begin
      s1_q <= s_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // conditions need scl high on both samples around the sda edge
  logic scl_hi, start_ev, stop_ev, scl_fall, rise_ev, byte_ev, ack_rise, wp_q;
  assign scl_hi   = s2_q[3] & s3_q[3];
  assign start_ev = scl_hi & s3_q[2] & ~s2_q[2];
  assign stop_ev  = scl_hi & ~s3_q[2] & s2_q[2];
  assign scl_fall = s3_q[3] & ~s2_q[3];
  assign rise_ev  = s2_q[1] ^ s3_q[1];
  assign wp_q     = s2_q[0];

  // ==========================================================
  // transaction state
  sebf_state_e    st_q, st_d;
  logic [3:0]     cnt_q, cnt_d;
  logic [AW-1:0]  ptr_q, ptr_d;
  logic           ack_q, ack_d;
  logic           oe_q, oe_d;
  logic [PG_N-1:0] vld_q, vld_d;
  logic [DW-1:0]  pg_q [PG_N];
  logic [DW-1:0]  pg_d [PG_N];
  logic           wr_go;
  logic           busy_q;
  logic [DW-1:0]  rdata;
  logic [2:0]     bix;

  assign byte_ev  = rise_ev && (cnt_q == CNT_LAST_BIT);
  assign ack_rise = rise_ev && (cnt_q == CNT_ACK);
  assign bix      = 3'(CNT_LAST_BIT - cnt_q);

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    ptr_d = ptr_q;
    ack_d = ack_q;
    oe_d  = oe_q;
    vld_d = vld_q;
    pg_d  = pg_q;
    wr_go = 1'b0;
    if (start_ev) begin
      // fresh addressing byte expected, even mid-byte
      st_d  = ST_ADDR;
      cnt_d = '0;
      ack_d = 1'b0;
      oe_d  = 1'b1;
    end else if (stop_ev) begin
      // read is dropped; collected write data goes to the array
      wr_go = (st_q == ST_WDATA) && (|vld_q);
      st_d  = ST_IDLE;
      ack_d = 1'b0;
      oe_d  = 1'b1;
    end else begin
      if (rise_ev) begin
        cnt_d = (cnt_q == CNT_ACK) ? 4'h0 : cnt_q + 4'h1;
      end
      if (byte_ev) begin
        unique case (st_q)
          ST_ADDR: begin
            // silent while rewriting so the master can poll
            if (sh_q[7:4] == DEV_CODE && !busy_q) begin
              ack_d = 1'b1;
              st_d  = sh_q[ADR_RW_BIT] ? ST_RDATA : ST_WORD;
              if (!sh_q[ADR_RW_BIT]) begin
                ptr_d[AW-1] = sh_q[ADR_P0_BIT];
              end
            end else begin
              st_d = ST_IDLE;
            end
          end
          ST_WORD: begin
            ptr_d[DW-1:0] = sh_q;
            vld_d         = '0;
            ack_d         = 1'b1;
            st_d          = ST_WDATA;
          end
          ST_WDATA: begin
            // page offset rolls over, upper address bits stay put
            pg_d[ptr_q[PG_W-1:0]]  = sh_q;
            vld_d[ptr_q[PG_W-1:0]] = 1'b1;
            ptr_d[PG_W-1:0]        = ptr_q[PG_W-1:0] + 4'h1;
            ack_d                  = 1'b1;
          end
          ST_IDLE, ST_RDATA: begin
          end
        endcase
      end
      // master answered with no acknowledge: read over
      if (ack_rise && st_q == ST_RDATA && sh_q[0]) begin
        st_d = ST_IDLE;
      end
      // drive changes only after scl falls
      if (scl_fall) begin
        if (cnt_q == CNT_ACK) begin
          oe_d  = ~ack_q;
          ack_d = 1'b0;
        end else if (st_q == ST_RDATA) begin
          oe_d = rdata[bix];
          if (cnt_q == CNT_LAST_BIT) begin
            ptr_d = ptr_q + 9'h001;
          end
        end else begin
          oe_d = 1'b1;
        end
      end
    end
  end

  // pointer survives every transaction, only reset clears it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q  <= ST_IDLE;
      cnt_q <= '0;
      ptr_q <= PTR_RST;
      ack_q <= 1'b0;
      oe_q  <= 1'b1;
      vld_q <= '0;
      pg_q  <= '{default: '0};
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      ptr_q <= ptr_d;
      ack_q <= ack_d;
      oe_q  <= oe_d;
      vld_q <= vld_d;
      pg_q  <= pg_d;
    end
  end

  // open drain: data is always low, only the enable moves
  assign sda_o    = 1'b0;
  assign sda_oe_n = oe_q;

  // ==========================================================
  // internal rewrite sequencer
  logic [WR_CNT_W-1:0] wr_cnt_q, wr_cnt_d;
  logic [PG_W:0]       idx_q, idx_d;
  logic                busy_d, prot, mem_we;
  logic [AW-1:0]       mem_wa;

  // protected half still runs the full busy time, only the store is dropped
  assign prot   = wp_q && ptr_q[AW-1];
  assign mem_we = busy_q && !idx_q[PG_W] && vld_q[idx_q[PG_W-1:0]] && !prot;
  assign mem_wa = {ptr_q[AW-1:PG_W], idx_q[PG_W-1:0]};

  always_comb begin
    busy_d   = busy_q;
    wr_cnt_d = wr_cnt_q;
    idx_d    = idx_q;
    if (wr_go) begin
      busy_d   = 1'b1;
      wr_cnt_d = '0;
      idx_d    = '0;
    end else if (busy_q) begin
      wr_cnt_d = wr_cnt_q + 21'h000001;
      if (!idx_q[PG_W]) begin
        idx_d = idx_q + 5'h01;
      end
      if (wr_cnt_q == WR_CNT_W'(WR_CYCLES - 1)) begin
        busy_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q   <= 1'b0;
      wr_cnt_q <= '0;
      idx_q    <= '0;
    end else begin
      busy_q   <= busy_d;
      wr_cnt_q <= wr_cnt_d;
      idx_q    <= idx_d;
    end
  end

  assign busy = busy_q;

  sebf_mem u_mem (
    .clk    (clk),
    .arst_n (arst_n),
    .we     (mem_we),
    .wa     (mem_wa),
    .wd     (pg_q[idx_q[PG_W-1:0]]),
    .ra     (ptr_q),
    .rd_q   (rdata)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_start;
    start_ev |=> (st_q == ST_ADDR) && (cnt_q == 4'h0) && oe_q;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_idle_hold;
    (st_q == ST_IDLE) && !start_ev |=> (st_q == ST_IDLE) && !ack_q;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("left idle without start");

  property p_stop_read;
    stop_ev && (st_q == ST_RDATA) |=> (st_q == ST_IDLE) && oe_q ##1 (st_q == ST_IDLE);
  endproperty
  a_stop_read: assert property (p_stop_read) else $error("read not dropped");

  property p_stop_write;
    stop_ev && (st_q == ST_WDATA) && (|vld_q) |=> busy_q [*8];
  endproperty
  a_stop_write: assert property (p_stop_write) else $error("rewrite not launched");

  property p_drive_in_txn;
    !oe_q |-> $past(st_q) != ST_IDLE || $past(cnt_q) == CNT_ACK;
  endproperty
  a_drive_in_txn: assert property (p_drive_in_txn) else $error("drove sda in standby");

  property p_drive_on_fall;
    $changed(oe_q) |-> $past(scl_fall || start_ev || stop_ev);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall) else $error("sda moved off scl fall");

  property p_protect;
    mem_we |-> !(wp_q && mem_wa[AW-1]);
  endproperty
  a_protect: assert property (p_protect) else $error("write into protected half");

  property p_wr_time;
    $fell(busy_q) |-> $past(wr_cnt_q) == WR_CNT_W'(WR_CYCLES - 1);
  endproperty
  a_wr_time: assert property (p_wr_time) else $error("rewrite length wrong");

  property p_busy_silent;
    busy_q && byte_ev && (st_q == ST_ADDR) |=> !ack_q && (st_q == ST_IDLE);
  endproperty
  a_busy_silent: assert property (p_busy_silent) else $error("acked while rewriting");

  property p_ptr_keep;
    (st_q == ST_IDLE) && !start_ev && !busy_q |=> $stable(ptr_q);
  endproperty
  a_ptr_keep: assert property (p_ptr_keep) else $error("pointer lost in standby");

endmodule

// file: hw/sebf_pkg.sv
// shared constants for the serial eeprom bus front end
// assumes a 125 MHz system clock and a bus master that drives scl
package sebf_pkg;

  // ==========================================================
  // timing
  localparam int CLK_MHZ     = 125;
  localparam int T_WR_TYP_US = 4000;   // typical internal rewrite duration, us
  localparam int T_WR_MAX_US = 10000;  // longest internal rewrite duration, us
  localparam int WR_TYP_CYC  = T_WR_TYP_US * CLK_MHZ;
  localparam int WR_MAX_CYC  = T_WR_MAX_US * CLK_MHZ;
  localparam int WR_CNT_W    = 21;     // holds WR_MAX_CYC

  // ==========================================================
  // array and framing
  localparam int AW       = 9;         // 512 words
  localparam int DW       = 8;
  localparam int PG_W     = 4;         // 16 byte page
  localparam int PG_N     = 16;
  localparam logic [3:0] CNT_LAST_BIT = 4'h7;
  localparam logic [3:0] CNT_ACK      = 4'h8;
  localparam int ADR_RW_BIT = 0;
  localparam int ADR_P0_BIT = 1;
  localparam logic [AW-1:0] PTR_RST = 9'h000;
  // arbitrary device code, not tied to any real part
  localparam logic [3:0] DEV_CODE = 4'h5;

  // ==========================================================
  // transaction states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WORD,
    ST_WDATA,
    ST_RDATA
  } sebf_state_e;

endpackage

// file: hw/sebf_mem.sv
// byte array of the eeprom with one write port and a registered read
// assumes writes come from the rewrite sequencer on the system clock
module sebf_mem
  import sebf_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] wa,
  input  wire logic [DW-1:0] wd,
  input  wire logic [AW-1:0] ra,
  output logic      [DW-1:0] rd_q
);

  // ==========================================================
  // storage
  logic [DW-1:0] arr_q [2**AW];
  logic [DW-1:0] rd_d;

  // read data follows the address one cycle later
  always_comb begin
    rd_d = arr_q[ra];
  end

  // array itself carries no reset, contents are what was last written
  always_ff @(posedge clk) begin
    if (we) begin
      arr_q[wa] <= wd;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q <= '0;
    end else begin
      rd_q <= rd_d;
    end
  end

endmodule

// file: tb/sebf_master.sv
// two-wire bus master model: drives scl, pulls sda, reports acks and read bytes
// assumes sda comes back resolved with a pull-up; scl idles high between frames
module sebf_master (
  output logic       scl,
  output logic       sda_m,
  input  wire logic  sda,
  output logic [7:0] obs,
  output logic       obs_ev
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TH = 120; // half bit, slow enough for the 2ff sampling
  // ==========================================================
  // bus primitives
  // idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    obs = 8'h00;
    obs_ev = 1'b0;
  end
  // start: sda falls while scl high
  task automatic start();
    sda_m = 1'b1;
    #TH scl = 1'b1;
    #TH sda_m = 1'b0;
    #TH scl = 1'b0;
  endtask
  // scl low with sda left high, so no condition appears on the wire
  task automatic clk_low();
    #TH scl = 1'b0;
  endtask
  // stop: sda rises while scl high
  task automatic stop();
    #(TH/4) sda_m = 1'b0;
    #TH scl = 1'b1;
    #TH sda_m = 1'b1;
    #TH;
  endtask
  // one bit; sda moves a quarter after the fall, never with scl high
  task automatic bit_x(input logic b, output logic r);
    #(TH/4) sda_m = b;
    #(TH*3/4) scl = 1'b1;
    #(TH/2) r = sda;
    #(TH/2) scl = 1'b0;
  endtask
  // byte out msb first, the ack slot is reported
  task automatic send(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], r);
    end
    bit_x(1'b1, r);
    obs = {7'h00, r};
    obs_ev = ~obs_ev;
  endtask
  // byte in, then ack (0) or nack (1) from the master
  task automatic recv(input logic nack);
    logic [7:0] v;
    logic       r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, v[i]);
    end
    bit_x(nack, r);
    obs = v;
    obs_ev = ~obs_ev;
  endtask
  // byte in, then a stop inside the ninth slot cuts the read short
  task automatic recv_cut();
    logic [7:0] v;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, v[i]);
    end
    obs = v;
    obs_ev = ~obs_ev;
    stop();
  endtask
endmodule

// file: tb/test_serial_eeprom_bus_frontend.sv
// self-checking bench of the bus front end with a behavioural bus master
// assumes the hand-over contract: bits on scl rise, acks and data after scl fall
module test_serial_eeprom_bus_frontend
  import sebf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WRC = 600; // short rewrite, still longer than one polling byte
  // ==========================================================
  // wiring
  logic       clk, arst_n, wp, scl, sda_m, sda, sda_o, sda_oe_n, busy, obs_ev, r;
  logic [7:0] obs, d1, d2;
  logic [8:0] a1, a2;
  logic [7:0] exp_q[$];
  int         fail_count = 0;
  int         compares = 0;
  int         cyc = 0;
  // sda wire: pull-up and-ed with every pull-down
  assign sda = sda_m & (sda_oe_n ? 1'b1 : sda_o);
  sebf_frontend #(.WR_CYCLES(WRC)) sebf_frontend_i (.clk(clk), .arst_n(arst_n),
    .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .wp(wp), .busy(busy));
  sebf_master sebf_master_i (.scl(scl), .sda_m(sda_m), .sda(sda), .obs(obs),
    .obs_ev(obs_ev));
  // ==========================================================
  // checking
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // hang guard; the pin may only ever pull low
  always @(posedge clk) begin
    cyc++;
    if (sda_o !== 1'b0) begin
      fail_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, 1'b0, sda_o);
    end
    if (cyc == 60000) begin
      fail_count++;
      end_of_test();
    end
  end
  // result watcher: oldest note against each reported result
  // start late: the model's own time zero init must not look like a result
  initial begin
    #1;
    forever begin
      @(obs_ev);
      chk(exp_q.pop_front(), obs);
    end
  end
  // ==========================================================
  // transactions
  // byte write, polled while rewriting; busy must end in bounded time
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    int n;
    n = 0;
    sebf_master_i.start();
    exp_q.push_back(8'h00);
    sebf_master_i.send({DEV_CODE, 2'b00, a[8], 1'b0});
    exp_q.push_back(8'h00);
    sebf_master_i.send(a[7:0]);
    exp_q.push_back(8'h00);
    sebf_master_i.send(d);
    sebf_master_i.stop();
    repeat (4) @(negedge clk);
    chk(8'h01, {7'h00, busy});
    sebf_master_i.start();
    exp_q.push_back(8'h01);
    sebf_master_i.send({DEV_CODE, 4'h1});
    sebf_master_i.stop();
    while (busy !== 1'b0 && n < WRC + 50) begin
      @(negedge clk);
      n++;
    end
    chk(8'h00, {7'h00, busy});
  endtask
  // random read: word address, repeated start, one byte, nack, stop
  task automatic rd(input logic [8:0] a, input logic [7:0] d);
    sebf_master_i.start();
    exp_q.push_back(8'h00);
    sebf_master_i.send({DEV_CODE, 2'b00, a[8], 1'b0});
    exp_q.push_back(8'h00);
    sebf_master_i.send(a[7:0]);
    sebf_master_i.start(); // repeated start
    exp_q.push_back(8'h00);
    sebf_master_i.send({DEV_CODE, 4'h1});
    exp_q.push_back(d);
    sebf_master_i.recv(1'b1);
    sebf_master_i.stop();
  endtask
  // ==========================================================
  // main sequence
  initial begin
    arst_n = 1'b0;
    wp = 1'b0;
    void'($urandom(32'h23EF));
    repeat (20) @(negedge clk);
    chk(8'h02, {6'h00, sda_oe_n, busy});
    arst_n = 1'b1;
    repeat (8) @(negedge clk);
    wp = 1'($urandom); // only lower half is written until the protect test
    sebf_master_i.clk_low(); // bits without a start need scl low first
    exp_q.push_back(8'h01);
    sebf_master_i.send({DEV_CODE, 4'h0});
    sebf_master_i.stop();
    sebf_master_i.start();
    exp_q.push_back(8'h01); // wrong device code
    sebf_master_i.send({~DEV_CODE, 4'h0});
    sebf_master_i.stop();
    $display("test refusals done");
    a1 = {1'b0, 8'($urandom)};
    d1 = 8'($urandom);
    wr(a1, d1);
    rd(a1, d1);
    $display("test write read done");
    @(negedge clk);
    wp = 1'b0;
    a2 = {1'b1, 8'($urandom)};
    d2 = 8'($urandom);
    wr(a2, d2);
    @(negedge clk);
    wp = 1'b1;
    wr(a2, ~d2);
    rd(a2, d2);
    @(negedge clk);
    wp = 1'b0;
    $display("test protect done");
    // half a byte, then a fresh start must frame a new address byte
    sebf_master_i.start();
    for (int i = 0; i < 4; i++) begin
      sebf_master_i.bit_x(1'b1, r);
    end
    sebf_master_i.start();
    exp_q.push_back(8'h00);
    sebf_master_i.send({DEV_CODE, 4'h0});
    exp_q.push_back(8'h00);
    sebf_master_i.send(a1[7:0]);
    sebf_master_i.stop();
    repeat (8) @(negedge clk);
    chk(8'h00, {7'h00, busy});
    sebf_master_i.start();
    exp_q.push_back(8'h00);
    sebf_master_i.send({DEV_CODE, 4'h1});
    exp_q.push_back(d1);
    sebf_master_i.recv_cut();
    repeat (4) @(negedge clk);
    chk(8'h01, {7'h00, sda_oe_n});
    $display("test restart and current read done");
    repeat (20) @(negedge clk);
    chk(8'h00, 8'(exp_q.size()));
    end_of_test();
  end
endmodule
